// ===== src/rop_host_regs.vh
// constants for the raster-op host controller: register map, fields, timing
`ifndef ROP_HOST_REGS_VH
`define ROP_HOST_REGS_VH

// apb register offsets (byte addresses)
`define OFF_CMD        12'h000
`define OFF_STATUS     12'h004
`define OFF_WDATA      12'h008
`define OFF_RDATA      12'h00C
`define OFF_PAT_ADDR   12'h010
`define OFF_PAT_INDEX  12'h014
`define OFF_PAT_DATA   12'h018
`define OFF_RUN_LEN    12'h01C

// command register fields
`define CMD_OP_LSB     0
`define CMD_OP_MSB     2
`define CMD_ADDR_LSB   4
`define CMD_ADDR_MSB   7

// command codes
`define OP_REG_WRITE   3'h0
`define OP_REG_READ    3'h1
`define OP_SRC_LOAD    3'h2
`define OP_DST_LOAD    3'h3
`define OP_RESULT      3'h4
`define OP_SEQ_RUN     3'h5

// status bits
`define ST_BUSY        0
`define ST_DONE        1

// reset values
`define RST_CMD        32'h00000000
`define RST_WDATA      16'h0000
`define RST_RUN_LEN    16'h0000

// pin timing, ns, and derived cycle counts at the clock rate
`define CLK_PERIOD_NS  40
`define STROBE_W_NS    60
`define NLD_GAP_NS     150
`define SETUP_NS       50
`define HOLD_NS        30
`define STROBE_CYC     ((`STROBE_W_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC        ((`NLD_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC      ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC       ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== src/rop_word_mem.v
// small word memory holding source words for a sequenced run
`timescale 1ns/1ps
module rop_word_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  // clock
  input  wire          clk,
  // write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // read port, data registered
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // registered read keeps the memory inferable as block ram
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rop_word_mem

// ===== src/rop_host_ctrl.v
// host controller driving the raster-op alu pins, commanded over apb
`timescale 1ns/1ps
`include "rop_host_regs.vh"
// Requirements the document places on host and device
// RQ1: device takes bus data only on chip select plus write; drives only on read/result; the model also loads on source and dest strobes.
// RQ2: host keeps chip select asserted throughout each register read or write.
// RQ3: device drives addressed register while chip select and read asserted.
// RQ4: device captures bus into addressed register while chip select and write asserted.
// RQ5: device address inputs select exactly one register per access.
// RQ6: host never raises result strobe during chip select with read or write.
// RQ7: device drives function decoder output while result strobe asserted.
// RQ8: destination loads on trailing edge of its strobe, ignoring select and address.
// RQ9: each destination strobe pulse decrements the operation counter.
// RQ10: source strobe loads selected source register, other gets its old value.
// RQ11: shifter takes 16 contiguous bits of the 32-bit source concatenation.
// RQ12: nonzero low shift nibble gives the field offset from bit 0.
// RQ13: zero shift passes one source register unshifted, chosen by direction.
// RQ14: per bit, source, destination, pattern pick one of eight function bits.
// RQ15: index weights pattern 4, source 2, destination 1; AND is 88 hex.
// RQ16: result also readable as an ordinary alu output register.
// RQ17: every register readable and writable for context save and restore.
// RQ18: counter with width and masks keeps edge destination bits unaltered.
// RQ19: mask one at counter equal width, mask two at zero, else none.
// RQ20: strobe after counter zero reloads counter from width.
// RQ21: masking enable changes only on destination strobes.
// RQ22: host pulses destination strobe once after counter load, preloading one higher.
// RQ23: host reloads counter and pulses destination strobe on context leave and re-entry.
// RQ24: synchronous device samples strobes once per pulse on detected edges.
module rop_host_ctrl #(
  parameter MEM_AW = 6
) (
  // clock and reset
  input  wire        CLOCK,
  input  wire        RESET_N,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // device pins, active low strobes
  output reg         CS_N,
  output reg         RD_N,
  output reg         WR_N,
  output reg  [3:0]  ADDR,
  output reg         DEST_LOAD_STROBE_N,
  output reg         SOURCE_LOAD_STROBE_N,
  output reg         RESULT_OUT_STROBE_N,
  // shared data bus, three signals
  input  wire [15:0] DATA_IN,
  output reg  [15:0] DATA_OUT,
  output reg         DATA_OE
);
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_SETUP = 4'h1;
  localparam [3:0] S_PULSE = 4'h2;
  localparam [3:0] S_HOLD  = 4'h3;
  localparam [3:0] S_GAP   = 4'h4;
  localparam [3:0] S_FETCH = 4'h5;
  localparam [3:0] S_SAMP  = 4'h6;

  // cycle counts worked out wide, then cut to the counter width on purpose
  localparam integer STROBE_I = `STROBE_CYC;
  localparam integer SETUP_I  = `SETUP_CYC;
  localparam integer HOLD_I   = `HOLD_CYC;
  localparam integer GAP_I    = `GAP_CYC;
  localparam [3:0]   STROBE_CYC = STROBE_I[3:0];
  localparam [3:0]   SETUP_CYC  = SETUP_I[3:0];
  localparam [3:0]   HOLD_CYC   = HOLD_I[3:0];
  localparam [3:0]   GAP_CYC    = GAP_I[3:0];

  reg  [3:0]        state_r;
  reg  [3:0]        cnt_r;
  reg  [2:0]        op_r;
  reg  [3:0]        addr_r;
  reg  [15:0]       wdata_r;
  reg  [15:0]       rdata_r;
  reg               done_r;
  reg  [15:0]       run_len_r;
  reg  [15:0]       run_left_r;
  reg  [MEM_AW-1:0] pat_addr_r;
  reg  [MEM_AW-1:0] run_idx_r;
  wire [15:0]       mem_rdata;
  wire              busy = (state_r != S_IDLE);
  wire              wr_en = PSEL && PENABLE && PWRITE;
  wire              pat_we = wr_en && (PADDR == `OFF_PAT_DATA);

  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;

  // source words for sequenced runs
  rop_word_mem #(
    .AW (MEM_AW),
    .DW (16)
  ) u_mem (
    .clk   (CLOCK),
    .we    (pat_we),
    .waddr (pat_addr_r),
    .wdata (PWDATA[15:0]),
    .raddr (run_idx_r),
    .rdata (mem_rdata)
  );

  // apb read mux; unmapped offsets read zero
  always @* begin
    case (PADDR)
      `OFF_STATUS:    PRDATA = {30'h00000000, done_r, busy};
      `OFF_WDATA:     PRDATA = {16'h0000, wdata_r};
      `OFF_RDATA:     PRDATA = {16'h0000, rdata_r};
      `OFF_CMD:       PRDATA = {24'h000000, addr_r, 1'b0, op_r};
      `OFF_PAT_ADDR:  PRDATA = {{(32-MEM_AW){1'b0}}, pat_addr_r};
      `OFF_RUN_LEN:   PRDATA = {16'h0000, run_len_r};
      default:        PRDATA = 32'h00000000;
    endcase
  end

  // command sequencer; strobes stretched to exceed device minimum widths
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r              <= S_IDLE;
      cnt_r                <= 4'h0;
      op_r                 <= 3'h0;
      addr_r               <= 4'h0;
      wdata_r              <= `RST_WDATA;
      rdata_r              <= 16'h0000;
      done_r               <= 1'b0;
      run_len_r            <= `RST_RUN_LEN;
      run_left_r           <= 16'h0000;
      pat_addr_r           <= {MEM_AW{1'b0}};
      run_idx_r            <= {MEM_AW{1'b0}};
      CS_N                 <= 1'b1;
      RD_N                 <= 1'b1;
      WR_N                 <= 1'b1;
      ADDR                 <= 4'h0;
      DEST_LOAD_STROBE_N   <= 1'b1;
      SOURCE_LOAD_STROBE_N <= 1'b1;
      RESULT_OUT_STROBE_N  <= 1'b1;
      DATA_OUT             <= 16'h0000;
      DATA_OE              <= 1'b0;
    end else begin
      // software writes; pattern address auto-increments on each data write
      if (wr_en && PADDR == `OFF_WDATA && !busy) begin
        wdata_r <= PWDATA[15:0];
      end
      if (wr_en && PADDR == `OFF_RUN_LEN && !busy) begin
        run_len_r <= PWDATA[15:0];
      end
      if (wr_en && PADDR == `OFF_PAT_ADDR) begin
        pat_addr_r <= PWDATA[MEM_AW-1:0];
      end else if (pat_we) begin
        pat_addr_r <= pat_addr_r + {{(MEM_AW-1){1'b0}}, 1'b1};
      end
      // status clear on new command, set on completion wins below
      if (wr_en && PADDR == `OFF_CMD && !busy) begin
        done_r <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (wr_en && PADDR == `OFF_CMD) begin
            op_r       <= PWDATA[`CMD_OP_MSB:`CMD_OP_LSB];
            addr_r     <= PWDATA[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
            ADDR       <= PWDATA[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
            run_left_r <= run_len_r;
            run_idx_r  <= {MEM_AW{1'b0}};
            cnt_r      <= SETUP_CYC;
            state_r    <= S_SETUP;
            // select goes active first and stays for the whole access [RQ2]
            CS_N <= !(PWDATA[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_REG_WRITE ||
                      PWDATA[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_REG_READ);
            DATA_OUT <= wdata_r;
            // drive bus for writes and loads, never for reads or result [RQ1]
            DATA_OE <= (PWDATA[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_REG_WRITE ||
                        PWDATA[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_SRC_LOAD ||
                        PWDATA[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_DST_LOAD);
            if (PWDATA[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_SEQ_RUN) begin
              state_r <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          // memory read data lands a cycle later
          state_r <= S_SAMP;
        end
        S_SAMP: begin
          DATA_OUT <= mem_rdata;
          DATA_OE  <= 1'b1;
          cnt_r    <= SETUP_CYC;
          state_r  <= S_SETUP;
        end
        S_SETUP: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            cnt_r <= STROBE_CYC;
            state_r <= S_PULSE;
            case (op_r)
              `OP_REG_WRITE: WR_N <= 1'b0;                  // [RQ4]
              `OP_REG_READ:  RD_N <= 1'b0;                  // [RQ3]
              `OP_SRC_LOAD:  SOURCE_LOAD_STROBE_N <= 1'b0;
              `OP_DST_LOAD:  DEST_LOAD_STROBE_N <= 1'b0;    // [RQ22][RQ23]
              `OP_SEQ_RUN:   SOURCE_LOAD_STROBE_N <= 1'b0;
              // result only while select is idle [RQ6]
              `OP_RESULT:    RESULT_OUT_STROBE_N <= !CS_N;
              default:       state_r <= S_HOLD;
            endcase
          end
        end
        S_PULSE: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            // sample returned data just before releasing the strobe
            if (op_r == `OP_REG_READ || op_r == `OP_RESULT) begin
              rdata_r <= DATA_IN;
            end
            WR_N                 <= 1'b1;
            RD_N                 <= 1'b1;
            SOURCE_LOAD_STROBE_N <= 1'b1;
            DEST_LOAD_STROBE_N   <= 1'b1;   // trailing edge loads dest [RQ8]
            RESULT_OUT_STROBE_N  <= 1'b1;
            cnt_r   <= HOLD_CYC;
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            // data held past trailing edge, select dropped only afterwards [RQ2]
            CS_N    <= 1'b1;
            DATA_OE <= 1'b0;
            cnt_r   <= GAP_CYC;
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          // gap covers the minimum spacing between destination strobes [RQ9]
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (op_r == `OP_SEQ_RUN && run_left_r > 16'h0001) begin
            run_left_r <= run_left_r - 16'h0001;
            run_idx_r  <= run_idx_r + {{(MEM_AW-1){1'b0}}, 1'b1};
            state_r    <= S_FETCH;
          end else begin
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // rop_host_ctrl

// ===== bench/rop_host_ctrl_assertions.sv
// pin and bus checks for the raster-op host controller
`timescale 1ns/1ps
module rop_host_ctrl_assertions (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  // device pins
  input wire logic        CS_N,
  input wire logic        RD_N,
  input wire logic        WR_N,
  input wire logic [3:0]  ADDR,
  input wire logic        DEST_LOAD_STROBE_N,
  input wire logic        SOURCE_LOAD_STROBE_N,
  input wire logic        RESULT_OUT_STROBE_N,
  input wire logic [15:0] DATA_OUT,
  input wire logic        DATA_OE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // strobe low two cycles, then released
  sequence s_wr;
    !WR_N ##1 WR_N;
  endsequence
  sequence s_rd;
    !RD_N ##1 RD_N;
  endsequence
  a_write_width: assert property ($fell(WR_N) |=> s_wr)
    else $error("write pulse width");
  a_read_width: assert property ($fell(RD_N) |=> s_rd)
    else $error("read pulse width");
  a_select_held: assert property (($fell(WR_N) || $fell(RD_N)) |-> (!CS_N && $stable(ADDR)) [*3])
    else $error("select dropped in access");
  a_result_apart: assert property (!RESULT_OUT_STROBE_N |-> CS_N)
    else $error("result strobe with select");
  a_one_strobe: assert property ($onehot0(~{RD_N, WR_N, DEST_LOAD_STROBE_N, SOURCE_LOAD_STROBE_N, RESULT_OUT_STROBE_N}))
    else $error("strobes overlap");
  a_write_data: assert property (!WR_N |-> DATA_OE && $stable(DATA_OUT))
    else $error("write data not held");
  a_bus_free: assert property ((!RD_N || !RESULT_OUT_STROBE_N) |-> !DATA_OE)
    else $error("host drives during device drive");
  a_dest_hold: assert property ($rose(DEST_LOAD_STROBE_N) |-> DATA_OE && $stable(DATA_OUT))
    else $error("dest data not held at trailing edge");
  a_dest_gap: assert property ($rose(DEST_LOAD_STROBE_N) |-> DEST_LOAD_STROBE_N [*4])
    else $error("dest pulses too close");
  a_src_hold: assert property ($rose(SOURCE_LOAD_STROBE_N) |-> DATA_OE)
    else $error("source data not held");
endmodule // rop_host_ctrl_assertions

bind rop_host_ctrl rop_host_ctrl_assertions chk (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ADDR(ADDR),
  .DEST_LOAD_STROBE_N(DEST_LOAD_STROBE_N), .SOURCE_LOAD_STROBE_N(SOURCE_LOAD_STROBE_N),
  .RESULT_OUT_STROBE_N(RESULT_OUT_STROBE_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));

// ===== bench/rop_device_model.sv
// behavioural raster-op alu behind the controller pins
`timescale 1ns/1ps
module rop_device_model (
  // host strobes, active low
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        dld_n,
  input  wire logic        sld_n,
  input  wire logic        aout_n,
  input  wire logic [3:0]  addr,
  // resolved bus and own drive
  input  wire logic [15:0] bus,
  output logic      [15:0] q,
  output logic             drv
);
  // 0 src1, 1 src2, 2 dest, 3 pattern, 4 function, 5 dir/shift, 6 width, 7-8 masks, 9 count
  logic [15:0] r [0:10];
  logic [15:0] s, f, m, nxt;
  logic        m1_r, m2_r;
  // shifter, mask choice and per-bit selector
  always_comb begin
    s = (r[5][3:0] != 4'h0) ? 16'({r[1], r[0]} >> r[5][3:0]) : r[r[5][4]];
    m = m1_r ? r[7] : m2_r ? r[8] : 16'h0000;
    for (int k = 0; k < 16; k++)
      f[k] = m[k] ? r[2][k] : r[4][{r[3][k], s[k], r[2][k]}];
    q = (!aout_n || addr == 4'hB) ? f : (addr < 4'hB) ? r[addr] : 16'h0000;
    drv = !aout_n || (!cs_n && !rd_n);
  end
  // writes land once, at the write strobe's trailing edge
  always @(posedge wr_n)
    if (!cs_n && addr < 4'hB)
      r[addr] <= bus;
  // select and address play no part in a destination load
  always @(posedge dld_n) begin
    nxt = (r[9] == 16'h0000) ? r[6] : r[9] - 16'h0001;
    r[2] <= bus;
    r[9] <= nxt;
    m1_r <= nxt == r[6];
    m2_r <= nxt == 16'h0000;
  end
  // the loaded half hands its old word to the other half
  always @(posedge sld_n) begin
    r[r[5][4]] <= bus;
    r[!r[5][4]] <= r[r[5][4]];
  end
endmodule // rop_device_model

// ===== bench/rop_host_ctrl_tb_top.sv
// self-checking bench for the raster-op host controller
`timescale 1ns/1ps
`include "rop_host_regs.vh"
module rop_host_ctrl_tb_top;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        cs_n, rd_n, wr_n, dld_n, sld_n, aout_n, oe, drv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  addr;
  logic [15:0] dout, q, bus, a, b, d, f, m1, m2;
  logic [15:0] last = 16'h0000;
  logic [15:0] v [0:15];
  int          bad_count, checks, i;
  // a released bus shows the inverse of its last driven value
  assign bus = oe ? dout : drv ? q : ~last;
  always @(posedge clock) if (oe || drv) last <= bus;
  rop_host_ctrl dut (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr),
    .DEST_LOAD_STROBE_N(dld_n), .SOURCE_LOAD_STROBE_N(sld_n),
    .RESULT_OUT_STROBE_N(aout_n), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(oe));
  rop_device_model device (.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .dld_n(dld_n), .sld_n(sld_n),
    .aout_n(aout_n), .addr(addr), .bus(bus), .q(q), .drv(drv));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task close_out;
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic [11:0] ad, input logic w, input logic [31:0] wd);
    int n;
    logic rdy, err;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // answer taken settled mid-cycle, as it stands at the sampling edge
    do begin
      @(negedge clock);
      rdy = pready;
      err = pslverr;
      rv = prdata;
      @(posedge clock);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", 32'h00000000, {31'h0, err});
    if (n >= 50) begin
      bad_count++;
      close_out;
    end
  endtask
  // one device command, polled until idle; ends holding the read word
  task dev(input logic [2:0] op, input logic [3:0] ra, input logic [15:0] wd);
    int n;
    n = 0;
    apb(`OFF_WDATA, 1'b1, {16'h0000, wd});
    apb(`OFF_CMD, 1'b1, {24'h000000, ra, 1'b0, op});
    do begin
      apb(`OFF_STATUS, 1'b0, 32'h00000000);
      n++;
    end while (rv[`ST_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) begin
      bad_count++;
      close_out;
    end
    chk("done", 32'h00000001, {31'h0, rv[`ST_DONE]});
    apb(`OFF_RDATA, 1'b0, 32'h00000000);
  endtask
  function automatic logic [15:0] rop(logic [7:0] fc, logic [15:0] p, s, dd);
    for (int k = 0; k < 16; k++)
      rop[k] = fc[{p[k], s[k], dd[k]}];
  endfunction
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset_n = 1'b0;
    bad_count = 0;
    checks = 0;
    void'($urandom(60));
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    apb(12'h020, 1'b0, 32'h00000000);
    chk("unmapped", 32'h00000000, rv);
    // fill all plain registers first, then read each back
    for (i = 3; i < 11; i++) begin
      v[i] = $urandom;
      dev(`OP_REG_WRITE, i[3:0], v[i]);
    end
    for (i = 3; i < 11; i++) begin
      dev(`OP_REG_READ, i[3:0], 16'h0000);
      chk("reg", {16'h0000, v[i]}, rv);
    end
    // random functions, unshifted source in both directions, masks off
    dev(`OP_REG_WRITE, 4'h6, 16'h0005);
    for (i = 0; i < 8; i++) begin
      f = (i == 0) ? 16'h0088 : 16'($urandom % 256);
      a = $urandom;
      b = $urandom;
      m1 = $urandom;
      dev(`OP_REG_WRITE, 4'h4, f);
      dev(`OP_REG_WRITE, 4'h3, m1);
      dev(`OP_REG_WRITE, 4'h5, {11'h000, i[0], 4'h0});
      dev(`OP_REG_WRITE, 4'h9, 16'h0009);
      dev(`OP_SRC_LOAD, 4'h0, a);
      dev(`OP_DST_LOAD, 4'hF, b);
      dev(`OP_RESULT, 4'h0, 16'h0000);
      chk("result", {16'h0000, rop(f[7:0], m1, a, b)}, rv);
      dev(`OP_REG_READ, 4'hB, 16'h0000);
      chk("alu reg", {16'h0000, rop(f[7:0], m1, a, b)}, rv);
    end
    // two loads chain through the pair, then a shifted field
    for (i = 0; i < 2; i++) begin
      a = $urandom;
      b = $urandom;
      d = (i == 0) ? 16'h000F : 16'($urandom % 15 + 1);
      dev(`OP_REG_WRITE, 4'h5, d);
      dev(`OP_REG_WRITE, 4'h4, 16'h00CC);
      dev(`OP_SRC_LOAD, 4'h0, a);
      dev(`OP_SRC_LOAD, 4'h0, b);
      dev(`OP_RESULT, 4'h0, 16'h0000);
      chk("shifted", {16'h0000, 16'({a, b} >> d[3:0])}, rv);
      dev(`OP_REG_READ, 4'h1, 16'h0000);
      chk("src pair", {16'h0000, a}, rv);
    end
    // row of width 2: preload one above, dummy load, then reload
    m1 = $urandom;
    m2 = $urandom;
    dev(`OP_REG_WRITE, 4'h6, 16'h0002);
    dev(`OP_REG_WRITE, 4'h7, m1);
    dev(`OP_REG_WRITE, 4'h8, m2);
    dev(`OP_REG_WRITE, 4'h4, 16'h00FF);
    dev(`OP_REG_WRITE, 4'h9, 16'h0003);
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      b = (i == 2) ? m2 : (i == 1) ? 16'h0000 : m1;
      dev(`OP_DST_LOAD, 4'h0, d);
      dev(`OP_RESULT, 4'h0, 16'h0000);
      chk("masked", {16'h0000, d | ~b}, rv);
    end
    // a count write alone leaves the mask choice alone
    dev(`OP_REG_WRITE, 4'h9, 16'h0000);
    dev(`OP_RESULT, 4'h0, 16'h0000);
    chk("mask hold", {16'h0000, d | ~m1}, rv);
    // context re-entry: reload count and strobe again picks the mask afresh
    dev(`OP_REG_WRITE, 4'h9, 16'h0002);
    dev(`OP_DST_LOAD, 4'h0, d);
    dev(`OP_RESULT, 4'h0, 16'h0000);
    chk("reentry", 32'h0000FFFF, rv);
    // sequenced run of two stored words through the source pair
    dev(`OP_REG_WRITE, 4'h5, 16'h0000);
    a = $urandom;
    b = $urandom;
    apb(`OFF_PAT_ADDR, 1'b1, 32'h00000000);
    apb(`OFF_PAT_DATA, 1'b1, {16'h0000, a});
    apb(`OFF_PAT_DATA, 1'b1, {16'h0000, b});
    apb(`OFF_RUN_LEN, 1'b1, 32'h00000002);
    dev(`OP_SEQ_RUN, 4'h0, 16'h0000);
    dev(`OP_REG_READ, 4'h0, 16'h0000);
    chk("run last", {16'h0000, b}, rv);
    dev(`OP_REG_READ, 4'h1, 16'h0000);
    chk("run first", {16'h0000, a}, rv);
    // own registers read back what software left in them
    apb(`OFF_RUN_LEN, 1'b0, 32'h00000000);
    chk("run len", 32'h00000002, rv);
    apb(`OFF_PAT_ADDR, 1'b0, 32'h00000000);
    chk("pat addr", 32'h00000002, rv);
    apb(`OFF_CMD, 1'b0, 32'h00000000);
    chk("cmd", 32'h00000011, rv);
    close_out;
  end
endmodule // rop_host_ctrl_tb_top
